// file: pkg/acd_pkg.sv
// shared constants and carriers for the audio control command decoder
package acd_pkg;
  // function addresses
  localparam logic [7:0] ACD_ADDR_SOURCE_SELECT = 8'h40;
  localparam logic [7:0] ACD_ADDR_LOUDNESS_ENABLE = 8'h41;
  localparam logic [7:0] ACD_ADDR_BASS_LEVEL = 8'h42;
  localparam logic [7:0] ACD_ADDR_TREBLE_LEVEL = 8'h43;
  localparam logic [7:0] ACD_ADDR_LEFT_ATTENUATION = 8'h44;
  localparam logic [7:0] ACD_ADDR_RIGHT_ATTENUATION = 8'h45;
  localparam logic [7:0] ACD_ADDR_OUTPUT_MATRIX = 8'h46;
  localparam logic [7:0] ACD_ADDR_FLAG_INPUTS = 8'h47;
  // field widths and codes
  localparam int ACD_BITS_PER_BYTE = 8;
  localparam logic [1:0] ACD_SRC_MUTE = 2'h3;
  localparam logic [3:0] ACD_TONE_FLAT = 4'h6;
  localparam logic [3:0] ACD_TONE_MAX = 4'hc;
  localparam logic [5:0] ACD_ATT_MAX = 6'h28;
  localparam logic [5:0] ACD_ATT_CODE_LIMIT = 6'h28;
  // matrix modes
  localparam logic [1:0] ACD_MTX_STEREO = 2'h0;
  localparam logic [1:0] ACD_MTX_LEFT = 2'h1;
  localparam logic [1:0] ACD_MTX_RIGHT = 2'h2;
  // end strobe low time
  localparam int ACD_END_PULSE_NS = 3000;
  localparam int ACD_CLK_NS = 10;
  localparam int ACD_END_PULSE_CYC = (ACD_END_PULSE_NS + ACD_CLK_NS - 1) / ACD_CLK_NS;

  // decoded function settings
  typedef struct packed {
    logic [1:0] source;
    logic mute;
    logic loudness;
    logic [3:0] bass;
    logic [3:0] treble;
    logic [5:0] left_att;
    logic [5:0] right_att;
    logic [1:0] matrix;
  } acd_settings_s;

  typedef enum logic [1:0] {ACD_IDLE, ACD_ADDR, ACD_VALUE} acd_phase_e;
endpackage

// file: hdl/acd_decoder.sv
// serial control decoder for a stereo audio processor
// Summary of operation
// R1 - value bits 1:0 at address 40 pick source one, two, three or mute on 11.
// R2 - value bits 2:0 at address 46 give left mono on 100, stereo on 101, right mono on 11x.
// R3 - bass at address 42 is a 4-bit code, 0110 flat and any 11xx the +12 dB maximum.
// R4 - treble at address 43 uses the bass coding, 0000 full cut and 11xx full boost.
// R5 - address 47 reads: during its eight value clocks the flags are driven on data, no write.
// R6 - the first flag input sits in value bit zero and the second in value bit one.
// R7 - left and right attenuation at 44 and 45 are 6-bit, 0 is 0 dB, 101xxx and 11xxxx are 80 dB.
// R8 - the last eight bits clocked in on rising edges while the strobe is low form the address.
// R9 - after eight value clocks a low strobe pulse of at least 3 us copies the value to its latch.
// R10 - after reset volume is minimum, tone flat, mute on, everything else off.
// R11 - flag pins are latched and reported active low on the open-drain data line.
`timescale 1ns/1ps
`default_nettype none
module acd_decoder
  import acd_pkg::*;
#(
  parameter int END_PULSE_CYC = ACD_END_PULSE_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // serial control bus
  input wire logic bus_clk_i,
  input wire logic frame_strobe_i,
  input wire logic data_i,
  output logic data_o,
  output logic data_oe_o,
  // digital flag pins
  input wire logic [1:0] flag_pins_i,
  // decoded settings
  output acd_settings_s settings_o
);

  // the low-time counter is 16 bits and saturates, so longer pulses cannot be timed
  if (END_PULSE_CYC < 1 || END_PULSE_CYC > 65535) begin : g_bad_pulse
    $error("END_PULSE_CYC out of range");
  end

  // whole state in one struct: the comb block edits a copy, one flop stage holds it
  typedef struct packed {
    logic [2:0] clk_sync;     // [0] first stage, [1] second, [2] previous
    logic [2:0] strobe_sync;
    logic [1:0] data_sync;
    logic [3:0] flag_sync;    // two stages for both pins
    acd_phase_e phase;
    logic [7:0] addr;
    logic [7:0] value;
    logic [3:0] value_cnt;
    logic [1:0] flags;
    logic [15:0] low_cnt;
    logic pulse_ok;
    logic data;
    logic data_oe;
    acd_settings_s settings;
  } acd_state_s;

  acd_state_s st_q;
  acd_state_s st_d;

  // edge pulses from the synchronised bus pins, one system clock wide, the synchronised strobe level and the read address decode
  logic clk_rise;
  logic strobe_rise;
  logic strobe_fall;
  logic strobe_lvl;
  logic is_read;

  // edges use stages two and three only, never the first flop
  // only rising bus clock edges matter: write bits are taken and read bits advance on them
  assign clk_rise = st_q.clk_sync[1] & ~st_q.clk_sync[2];
  assign strobe_lvl = st_q.strobe_sync[1];
  assign strobe_rise = strobe_lvl & ~st_q.strobe_sync[2];
  assign strobe_fall = ~strobe_lvl & st_q.strobe_sync[2];
  // the read decode looks at the address held since the strobe rose
  assign is_read = (st_q.addr == ACD_ADDR_FLAG_INPUTS);

  // next state
  always_comb begin
    st_d = st_q;
    st_d.clk_sync = {st_q.clk_sync[1:0], bus_clk_i};
    st_d.strobe_sync = {st_q.strobe_sync[1:0], frame_strobe_i};
    st_d.data_sync = {st_q.data_sync[0], data_i};
    st_d.flag_sync = {st_q.flag_sync[1:0], flag_pins_i};
    // low strobe time counter, saturating
    // counting in every phase lets the end pulse be timed from its very first cycle
    if (!strobe_lvl) begin
      if (st_q.low_cnt != 16'hffff) begin
        st_d.low_cnt = st_q.low_cnt + 16'h1;
      end
    end else begin
      st_d.low_cnt = 16'h0;
    end
    // frame walk: idle, address bits while the strobe is low, value bits after it rises
    unique case (st_q.phase)
      ACD_IDLE: begin
        // a falling strobe opens a frame; bus clocks seen while idle are ignored
        if (strobe_fall) begin
          st_d.phase = ACD_ADDR;
        end
      end
      ACD_ADDR: begin
        // more than eight address bits simply push the oldest ones out
        if (clk_rise) begin
          st_d.addr = {st_q.addr[6:0], st_q.data_sync[1]}; // R8
        end
        if (strobe_rise) begin
          st_d.phase = ACD_VALUE;
          st_d.value_cnt = 4'h0;
          st_d.pulse_ok = 1'b0;
          // flags sampled at the start of the value phase, held through the read
          st_d.flags = st_q.flag_sync[3:2]; // R11
        end
      end
      ACD_VALUE: begin
        // read: each bit is set up after the previous rising edge, so it stands
        // for a full bus clock before the host samples it; lsb goes last
        if (is_read && st_q.value_cnt < 4'h8) begin // R5
          // open drain: pin low pulls the line low, so a flag pin low reads as zero
          st_d.data = 1'b0;
          if (st_q.value_cnt == 4'h6) begin
            st_d.data_oe = ~st_q.flags[1]; // R6 R11
          end else if (st_q.value_cnt == 4'h7) begin
            st_d.data_oe = ~st_q.flags[0]; // R6 R11
          end else begin
            st_d.data_oe = 1'b0;
          end
        end else begin
          st_d.data_oe = 1'b0;
        end
        // a ninth value clock is ignored, so a long burst cannot shift the byte out
        if (clk_rise && st_q.value_cnt < 4'h8) begin
          st_d.value = {st_q.value[6:0], st_q.data_sync[1]};
          st_d.value_cnt = st_q.value_cnt + 4'h1;
        end
        if (strobe_fall) begin
          st_d.pulse_ok = 1'b0;
        end
        if (!strobe_lvl && st_q.low_cnt >= 16'(END_PULSE_CYC - 1)) begin
          st_d.pulse_ok = 1'b1; // R9
        end
        if (strobe_rise && st_q.pulse_ok) begin
          // end pulse completed: latch the value if eight bits arrived
          // settings move only here, so the audio path never sees a half-sent value
          st_d.phase = ACD_IDLE;
          st_d.data_oe = 1'b0;
          if (st_q.value_cnt == 4'h8 && !is_read) begin // R5 R9
            unique case (st_q.addr)
              // the mute code stays in the source field too, so both read back alike
              ACD_ADDR_SOURCE_SELECT: begin
                st_d.settings.source = st_q.value[1:0]; // R1
                st_d.settings.mute = (st_q.value[1:0] == ACD_SRC_MUTE); // R1
              end
              ACD_ADDR_LOUDNESS_ENABLE: st_d.settings.loudness = st_q.value[0];
              ACD_ADDR_BASS_LEVEL: begin
                // 11xx all saturate at maximum boost
                st_d.settings.bass = (st_q.value[3:2] == 2'h3) ? ACD_TONE_MAX
                                     : st_q.value[3:0]; // R3
              end
              ACD_ADDR_TREBLE_LEVEL: begin
                st_d.settings.treble = (st_q.value[3:2] == 2'h3) ? ACD_TONE_MAX
                                       : st_q.value[3:0]; // R4
              end
              // codes past forty steps all mean the 80 dB floor; store the floor itself
              ACD_ADDR_LEFT_ATTENUATION: begin
                st_d.settings.left_att = (st_q.value[5:0] >= ACD_ATT_CODE_LIMIT)
                                         ? ACD_ATT_MAX : st_q.value[5:0]; // R7
              end
              ACD_ADDR_RIGHT_ATTENUATION: begin
                st_d.settings.right_att = (st_q.value[5:0] >= ACD_ATT_CODE_LIMIT)
                                          ? ACD_ATT_MAX : st_q.value[5:0]; // R7
              end
              ACD_ADDR_OUTPUT_MATRIX: begin
                // codes 0xx are undefined and leave the matrix unchanged
                if (st_q.value[2:1] == 2'h3) begin
                  st_d.settings.matrix = ACD_MTX_RIGHT; // R2
                end else if (st_q.value[2:0] == 3'h4) begin
                  st_d.settings.matrix = ACD_MTX_LEFT; // R2
                end else if (st_q.value[2:0] == 3'h5) begin
                  st_d.settings.matrix = ACD_MTX_STEREO; // R2
                end
              end
              default: ; // other addresses are for other devices
            endcase
          end
        end else if (strobe_rise) begin
          // end pulse too short: drop the frame, so the long address-phase low
          // of the next frame can never latch this stale value later
          st_d.phase = ACD_IDLE; // R9
          st_d.data_oe = 1'b0;
        end
      end
      default: st_d.phase = ACD_IDLE;
    endcase
  end

  // state register with power-on defaults
  // reset is asynchronous so the audio path is muted before the first clock edge
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= '0;
      st_q.clk_sync <= 3'h7;
      st_q.strobe_sync <= 3'h7;
      st_q.phase <= ACD_IDLE;
      st_q.settings.source <= ACD_SRC_MUTE; // R10
      st_q.settings.mute <= 1'b1; // R10
      st_q.settings.bass <= ACD_TONE_FLAT; // R10
      st_q.settings.treble <= ACD_TONE_FLAT; // R10
      st_q.settings.left_att <= ACD_ATT_MAX; // R10
      st_q.settings.right_att <= ACD_ATT_MAX; // R10
      st_q.settings.matrix <= ACD_MTX_STEREO;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign data_o = st_q.data;
  assign data_oe_o = st_q.data_oe;
  // data_o is fixed low: the pin is open drain and only the enable moves
  assign settings_o = st_q.settings;

endmodule
`default_nettype wire

// file: verification/acd_decoder_sva.sv
// assertion checker for the audio control command decoder
`timescale 1ns/1ps
`default_nettype none
module acd_decoder_chk
  import acd_pkg::*;
(
  // clock, strobe and device outputs
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic frame_strobe_i,
  input wire logic data_o,
  input wire logic data_oe_o,
  input wire acd_settings_s settings_o
);
  localparam acd_settings_s RST_V = '{ACD_SRC_MUTE, 1'b1, 1'b0, ACD_TONE_FLAT,
    ACD_TONE_FLAT, ACD_ATT_MAX, ACD_ATT_MAX, ACD_MTX_STEREO};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // four samples low means address phase or end pulse, never a read bit
  sequence s_strobe_low;
    !frame_strobe_i [*4];
  endsequence
  property p_oe_value; s_strobe_low |-> !data_oe_o; endproperty
  a_oe_value: assert property (p_oe_value) else $error("data driven, strobe low");
  property p_drain; data_oe_o |-> data_o == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("data driven high");
  property p_mute; settings_o.mute == (settings_o.source == ACD_SRC_MUTE); endproperty
  a_mute: assert property (p_mute) else $error("mute code");
  property p_tone; settings_o.bass <= ACD_TONE_MAX && settings_o.treble <= ACD_TONE_MAX; endproperty
  a_tone: assert property (p_tone) else $error("tone code");
  property p_att; settings_o.left_att <= ACD_ATT_MAX && settings_o.right_att <= ACD_ATT_MAX; endproperty
  a_att: assert property (p_att) else $error("attenuation code");
  property p_matrix; settings_o.matrix != 2'h3; endproperty
  a_matrix: assert property (p_matrix) else $error("matrix code");
  // a settings change follows a strobe rise: strobe high two samples back and low seven samples back
  property p_latch; !$stable(settings_o) |-> $past(frame_strobe_i, 2) && !$past(frame_strobe_i, 7); endproperty
  a_latch: assert property (p_latch) else $error("settings moved off frame end");
  property p_reset; $fell(reset_i) |-> settings_o == RST_V; endproperty
  a_reset: assert property (p_reset) else $error("reset settings");
endmodule
bind acd_decoder acd_decoder_chk chk_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .frame_strobe_i(frame_strobe_i), .data_o(data_o), .data_oe_o(data_oe_o),
  .settings_o(settings_o));
`default_nettype wire

// file: verification/acd_host_model.sv
// host model driving the three-wire serial control bus
`timescale 1ns/1ps
`default_nettype none
module acd_host_model (
  // bus wires
  output logic bus_clk_o,
  output logic strobe_o,
  output wire logic line_o,
  input wire logic oe_i
);
  logic drive_low;
  // open drain with pull-up: a released line reads one
  assign line_o = !(drive_low || oe_i);
  initial begin
    bus_clk_o = 1'b1;
    strobe_o = 1'b1;
    drive_low = 1'b0;
  end
  // one frame, msb first, 80 ns bus clock; line sampled before each rise
  task automatic xfer(input logic [15:0] w, input int end_ns, output logic [7:0] rd);
    strobe_o = 1'b0;
    #40;
    for (int i = 15; i >= 0; i--) begin
      bus_clk_o = 1'b0;
      strobe_o = (i < 8);
      drive_low = !w[i];
      #40;
      rd = {rd[6:0], line_o};
      bus_clk_o = 1'b1;
      #40;
    end
    drive_low = 1'b0;
    #200 strobe_o = 1'b0;
    #end_ns strobe_o = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the audio control command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench
  import acd_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] flags = 2'h3;
  logic [7:0] rd;
  acd_settings_s settings;
  acd_settings_s exp_s;
  int mismatches = 0;
  int comparisons = 0;
  wire logic bus_clk;
  wire logic strobe;
  wire logic line;
  wire logic oe;
  // 100 MHz system clock
  always #5 clk_sys_i = ~clk_sys_i;
  acd_host_model host_u (.bus_clk_o(bus_clk), .strobe_o(strobe), .line_o(line), .oe_i(oe));
  // short end pulse count keeps frames brief
  acd_decoder #(.END_PULSE_CYC(30)) dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .bus_clk_i(bus_clk), .frame_strobe_i(strobe), .data_i(line), .data_o(), .data_oe_o(oe),
    .flag_pins_i(flags), .settings_o(settings));
  task automatic cmp(input logic [25:0] got, input logic [25:0] want);
    comparisons++;
    if (got !== want) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  // one write frame; end pulse in ns, then settings checked
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input int p);
    host_u.xfer({a, v}, p, rd);
    cmp(settings, exp_s);
  endtask
  task automatic t_source();
    for (int s = 0; s < 4; s++) begin
      exp_s.source = 2'(s);
      exp_s.mute = (s == 3);
      wr(ACD_ADDR_SOURCE_SELECT, 8'(s) | 8'hfc, 400);
    end
  endtask
  // codes 0xx carry no mode and must leave the matrix alone
  task automatic t_matrix();
    for (int c = 4; c < 8; c++) begin
      exp_s.matrix = (c == 4) ? ACD_MTX_LEFT : (c == 5) ? ACD_MTX_STEREO : ACD_MTX_RIGHT;
      wr(ACD_ADDR_OUTPUT_MATRIX, 8'(c), 400);
    end
    wr(ACD_ADDR_OUTPUT_MATRIX, 8'h03, 400);
  endtask
  task automatic t_levels();
    for (int c = 0; c < 16; c += 3) begin
      exp_s.bass = (c > 11) ? ACD_TONE_MAX : 4'(c);
      wr(ACD_ADDR_BASS_LEVEL, 8'(c), 400);
      exp_s.treble = exp_s.bass;
      wr(ACD_ADDR_TREBLE_LEVEL, 8'(c), 400);
    end
    for (int c = 0; c < 64; c += 20) begin
      exp_s.left_att = (c >= 40) ? ACD_ATT_MAX : 6'(c);
      wr(ACD_ADDR_LEFT_ATTENUATION, 8'(c) | 8'hc0, 400);
      exp_s.right_att = (c + 1 >= 40) ? ACD_ATT_MAX : 6'(c + 1);
      wr(ACD_ADDR_RIGHT_ATTENUATION, 8'(c + 1), 400);
    end
  endtask
  // flags read low-active; the read must not write anything
  task automatic t_read();
    for (int f = 1; f < 3; f++) begin
      flags = 2'(f);
      wr(ACD_ADDR_FLAG_INPUTS, 8'hff, 400);
      cmp(26'(rd), 26'({6'h3f, 2'(f)}));
    end
  endtask
  // a short end pulse drops the frame; the next frame must not latch it late
  task automatic t_refuse();
    wr(ACD_ADDR_LOUDNESS_ENABLE, 8'h01, 100);
    exp_s.bass = ACD_TONE_FLAT;
    wr(ACD_ADDR_BASS_LEVEL, 8'h06, 400);
    exp_s.loudness = 1'b1;
    wr(ACD_ADDR_LOUDNESS_ENABLE, 8'h01, 400);
    wr(8'h48, 8'h00, 400);
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // reset, then scenarios; changes land on falling edges
  initial begin
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i) reset_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    exp_s = '{ACD_SRC_MUTE, 1'b1, 1'b0, ACD_TONE_FLAT, ACD_TONE_FLAT, ACD_ATT_MAX,
      ACD_ATT_MAX, ACD_MTX_STEREO};
    cmp(settings, exp_s);
    t_source();
    t_matrix();
    t_levels();
    t_read();
    t_refuse();
    report_and_stop();
  end
  // about 35 frames of 2.3 us each; two and a half times that is a hang
  initial begin
    #200us;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
